/* pkg/spm_pkg.sv */
/*
  constants for the spi write-parity, analog monitor and scratch register block.
  assumes 16-bit spi frames, msb first, one frame per chip-select low period.
*/
package spm_pkg;

  // frame layout
  localparam logic [4:0] FRAME_BITS_CNT = 5'h10;
  localparam logic [4:0] HEAD_BITS_CNT  = 5'h07;
  localparam int         CMD_HI         = 15;
  localparam int         CMD_LO         = 14;
  localparam int         ADDR_HI        = 13;
  localparam int         ADDR_LO        = 9;
  localparam int         PARITY_BIT     = 8;
  localparam int         DATA_HI        = 7;
  localparam int         DATA_LO        = 0;

  // command codes in the two top bits
  localparam logic [1:0] CMD_READ       = 2'h0;
  localparam logic [1:0] CMD_WRITE      = 2'h1;

  // register addresses
  localparam logic [4:0] ADDR_MONITOR   = 5'h00;
  localparam logic [4:0] ADDR_SCRATCH_A = 5'h01;
  localparam logic [4:0] ADDR_SCRATCH_D = 5'h04;
  localparam int         SCRATCH_COUNT  = 4;

  // analog_monitor_control fields
  localparam int         MON_SEL_HI     = 7;
  localparam int         MON_SEL_LO     = 5;
  localparam int         MON_RES_BIT    = 4;
  localparam int         MON_ATT_BIT    = 3;
  localparam logic [7:0] MON_WRITE_MASK = 8'hf8;
  localparam logic [7:0] MON_RESET      = 8'h00;
  localparam logic [7:0] SCRATCH_RESET  = 8'h00;
  localparam logic [7:0] READ_FILL      = 8'h00;

  // monitor source codes
  localparam logic [2:0] SRC_OFF         = 3'h0;
  localparam logic [2:0] SRC_REG_CURRENT = 3'h1;
  localparam logic [2:0] SRC_REFERENCE   = 3'h2;
  localparam logic [2:0] SRC_TEMPERATURE = 3'h3;
  localparam logic [2:0] SRC_IO_FIRST    = 3'h4;
  localparam logic [2:0] SRC_IO_SECOND   = 3'h5;
  localparam logic [2:0] SRC_SUPPLY      = 3'h6;
  localparam logic [2:0] SRC_SENSE       = 3'h7;

endpackage

/* src/spm_parity.sv */
/*
  odd-parity check of one 16-bit spi frame.
  assumes the frame is stable while its result is used.
*/
module spm_parity
  import spm_pkg::*;
(
  // frame
  input  wire logic [15:0] frame_i,
  // result
  output logic             parity_ok_o,
  output logic             expected_bit_o
);

  // bit eight high when the counted ones are even
  assign expected_bit_o = ~(^{frame_i[CMD_HI:ADDR_LO], frame_i[DATA_HI:DATA_LO]}); // RULE_02 RULE_03
  assign parity_ok_o    = (frame_i[PARITY_BIT] == expected_bit_o);

endmodule

/* src/spm_regs.sv */
/*
  spi slave holding the analog monitor select register and four scratch bytes,
  with optional write-frame parity check.
  assumes spi inputs synchronous to clk_i, sclk idle low, mosi sampled on rising
  sclk, miso shifted on falling sclk, sclk well below half the clk_i rate.
*/
// What this block does
// RULE_01 - parity only concerns write frames, top control bits 01.
// RULE_02 - parity counts ones in bits fifteen to nine and seven to zero.
// RULE_03 - host sets bit eight so the whole frame has odd ones.
// RULE_04 - parity is checked only while the setup parity enable is set.
// RULE_05 - without parity the host sends bit eight as zero.
// RULE_06 - monitor register: select 7..5, resistor 4, scaling 3, low bits zero.
// RULE_07 - select code picks one of eight analog sources, zero is off.
// RULE_08 - bit four one connects the internal resistor to ground.
// RULE_09 - bit three picks gain or attenuation, only for the i/o sources.
// RULE_10 - monitor clears on reset, regulator off, or leaving normal mode.
// RULE_11 - monitor access while regulator off is ignored and clears it.
// RULE_12 - four scratch bytes at 1..4, cleared only by power-on reset.
// RULE_13 - write frame: command, five-bit address, parity, eight data bits.
// RULE_14 - read-back frame returns fixed status then the register contents.
// RULE_15 - write with bad parity is discarded, register unchanged.
module spm_regs
  import spm_pkg::*;
(
  // clock and reset
  input  wire logic       clk_i,
  input  wire logic       sys_rst_i,
  // spi
  input  wire logic       spi_sclk_i,
  input  wire logic       spi_cs_n_i,
  input  wire logic       spi_mosi_i,
  output logic            spi_miso_o,
  // device state
  input  wire logic       parity_enable_i,
  input  wire logic       can_reg_on_i,
  input  wire logic       normal_mode_i,
  input  wire logic [7:0] fixed_status_i,
  input  wire logic [7:0] extended_status_i,
  // analog monitor controls
  output logic [2:0]      monitor_select_o,
  output logic            internal_sense_resistor_enable_o,
  output logic            io_attenuation_o,
  // events
  output logic            parity_error_o
);

  logic        sclk_q;
  logic        cs_n_q;
  logic [4:0]  bit_cnt;
  logic [15:0] rx;
  logic [15:0] tx;
  logic [7:0]  mon;
  logic [7:0]  scratch [SCRATCH_COUNT];
  logic [31:0] scratch_flat;
  logic [7:0]  rd_byte;
  logic [7:0]  head_byte;
  logic        parity_ok;
  logic        sclk_rise;
  logic        sclk_fall;
  logic        cs_fall;
  logic        cs_rise;
  logic        frame_end;
  logic        is_write;
  logic        parity_bad;
  logic        write_ok;
  logic        readback;
  logic        mon_blocked;
  logic [1:0]  cmd;
  logic [4:0]  addr;
  logic [7:0]  data;

  assign sclk_rise   = spi_sclk_i & ~sclk_q & ~spi_cs_n_i;
  assign sclk_fall   = ~spi_sclk_i & sclk_q & ~spi_cs_n_i;
  assign cs_fall     = ~spi_cs_n_i & cs_n_q;
  assign cs_rise     = spi_cs_n_i & ~cs_n_q;
  assign cmd         = rx[CMD_HI:CMD_LO];
  assign addr        = rx[ADDR_HI:ADDR_LO];
  assign data        = rx[DATA_HI:DATA_LO];
  assign frame_end   = cs_rise & (bit_cnt == FRAME_BITS_CNT); // RULE_13
  assign is_write    = frame_end & (cmd == CMD_WRITE); // RULE_01
  // bit eight of a write frame carries no meaning with parity off
  assign parity_bad  = is_write & parity_enable_i & ~parity_ok; // RULE_04 RULE_05
  assign write_ok    = is_write & ~parity_bad; // RULE_15
  assign mon_blocked = ~can_reg_on_i | ~normal_mode_i;
  assign head_byte   = {rx[6:0], spi_mosi_i};
  assign readback    = (head_byte[7:6] == CMD_READ) & head_byte[0]; // RULE_14

  spm_parity u_parity (
    .frame_i        (rx),
    .parity_ok_o    (parity_ok),
    .expected_bit_o ()
  );

  // edge detect and bit counter
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      sclk_q  <= 1'b0;
      cs_n_q  <= 1'b1;
      bit_cnt <= 5'h00;
      rx      <= 16'h0000;
    end else begin
      sclk_q <= spi_sclk_i;
      cs_n_q <= spi_cs_n_i;
      if (cs_fall) begin
        bit_cnt <= 5'h00;
      end else if (sclk_rise) begin
        rx <= {rx[14:0], spi_mosi_i};
        // saturate so overlong frames never match
        if (bit_cnt <= FRAME_BITS_CNT) begin
          bit_cnt <= bit_cnt + 5'h01;
        end
      end
    end
  end

  // read-back byte for the address in the head byte
  always_comb begin
    rd_byte = READ_FILL;
    if (head_byte[5:1] == ADDR_MONITOR) begin
      rd_byte = can_reg_on_i ? mon : READ_FILL; // RULE_11
    end else if (head_byte[5:1] >= ADDR_SCRATCH_A && head_byte[5:1] <= ADDR_SCRATCH_D) begin
      rd_byte = scratch[2'(head_byte[5:1] - ADDR_SCRATCH_A)];
    end
  end

  // miso shifter
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      tx         <= 16'h0000;
      spi_miso_o <= 1'b0;
    end else if (cs_fall) begin
      tx         <= {fixed_status_i, extended_status_i};
      spi_miso_o <= fixed_status_i[7];
    end else if (cs_rise) begin
      spi_miso_o <= 1'b0;
    end else if (sclk_fall) begin
      tx         <= {tx[14:0], 1'b0};
      spi_miso_o <= tx[14];
    end else if (sclk_rise && bit_cnt == HEAD_BITS_CNT && readback) begin
      // seven shifts done, low byte sits in bits 14..7
      tx[14:7] <= rd_byte; // RULE_14
    end
  end

  // analog monitor register
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      mon <= MON_RESET;
    end else if (mon_blocked) begin
      mon <= MON_RESET; // RULE_10 RULE_11
    end else if (write_ok && addr == ADDR_MONITOR) begin
      mon <= data & MON_WRITE_MASK; // RULE_06
    end
  end

  assign monitor_select_o                 = mon[MON_SEL_HI:MON_SEL_LO]; // RULE_07
  assign internal_sense_resistor_enable_o = mon[MON_RES_BIT]; // RULE_08

  // scaling only matters for the two i/o sources
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      io_attenuation_o <= 1'b0;
    end else begin
      io_attenuation_o <= mon[MON_ATT_BIT] & ((mon[MON_SEL_HI:MON_SEL_LO] == SRC_IO_FIRST) |
                          (mon[MON_SEL_HI:MON_SEL_LO] == SRC_IO_SECOND)); // RULE_09
    end
  end

  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      parity_error_o <= 1'b0;
    end else begin
      parity_error_o <= parity_bad; // RULE_15
    end
  end

  // scratch bytes
  genvar gi;
  generate
    for (gi = 0; gi < SCRATCH_COUNT; gi++) begin : g_scratch
      always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
          scratch[gi] <= SCRATCH_RESET;
        end else if (write_ok && addr == (ADDR_SCRATCH_A + 5'(gi))) begin
          scratch[gi] <= data; // RULE_12
        end
      end
      assign scratch_flat[8*gi +: 8] = scratch[gi];
    end
  endgenerate

  write_kind_a: assert property (@(posedge clk_i) disable iff (sys_rst_i) // RULE_01
    frame_end && cmd != CMD_WRITE |=> $stable(scratch_flat))
    else $error("non-write frame changed a scratch byte");

  parity_calc_a: assert property (@(posedge clk_i) disable iff (sys_rst_i) // RULE_02
    parity_ok == ($countones({rx[15:9], rx[7:0]}) % 2 != int'(rx[PARITY_BIT])))
    else $error("parity result does not match counted ones");

  parity_off_a: assert property (@(posedge clk_i) disable iff (sys_rst_i) // RULE_04
    is_write && !parity_enable_i && addr == ADDR_SCRATCH_A |=> scratch[0] == $past(data))
    else $error("write refused while parity disabled");

  mon_layout_a: assert property (@(posedge clk_i) disable iff (sys_rst_i) // RULE_06
    mon[2:0] == 3'h0)
    else $error("monitor low bits not zero");

  select_write_a: assert property (@(posedge clk_i) disable iff (sys_rst_i) // RULE_07
    write_ok && addr == ADDR_MONITOR && !mon_blocked |=>
      monitor_select_o == $past(data[MON_SEL_HI:MON_SEL_LO]))
    else $error("monitor select not taken from write");

  resistor_write_a: assert property (@(posedge clk_i) disable iff (sys_rst_i) // RULE_08
    write_ok && addr == ADDR_MONITOR && !mon_blocked |=>
      internal_sense_resistor_enable_o == $past(data[MON_RES_BIT]))
    else $error("resistor enable not taken from write");

  scaling_io_a: assert property (@(posedge clk_i) disable iff (sys_rst_i) // RULE_09
    monitor_select_o != SRC_IO_FIRST && monitor_select_o != SRC_IO_SECOND |=> !io_attenuation_o)
    else $error("attenuation active for non-io source");

  mon_clear_a: assert property (@(posedge clk_i) disable iff (sys_rst_i) // RULE_10
    mon_blocked |=> mon == MON_RESET [*1] ##0 monitor_select_o == SRC_OFF)
    else $error("monitor not cleared while blocked");

  mon_access_a: assert property (@(posedge clk_i) disable iff (sys_rst_i) // RULE_11
    frame_end && !can_reg_on_i && addr == ADDR_MONITOR |=> mon == MON_RESET)
    else $error("monitor access with regulator off not cleared");

  scratch_hold_a: assert property (@(posedge clk_i) disable iff (sys_rst_i) // RULE_12
    !write_ok |=> $stable(scratch_flat))
    else $error("scratch byte changed without write");

  frame_len_a: assert property (@(posedge clk_i) disable iff (sys_rst_i) // RULE_13
    cs_rise && bit_cnt != FRAME_BITS_CNT |=> $stable(scratch_flat))
    else $error("short or long frame was taken");

  readback_a: assert property (@(posedge clk_i) disable iff (sys_rst_i) // RULE_14
    sclk_rise && bit_cnt == HEAD_BITS_CNT && readback && !cs_fall |=> tx[14:7] == $past(rd_byte))
    else $error("read-back byte not loaded");

  parity_drop_a: assert property (@(posedge clk_i) disable iff (sys_rst_i) // RULE_15
    parity_bad |=> $stable(scratch_flat) && parity_error_o)
    else $error("bad-parity write not discarded");

endmodule

/* verif/spm_host.sv */
/*
  host model: spi master sending one frame of up to 16 bits per chip-select low period.
  assumes cpol 0, sample on rising sclk, and a clk_i much faster than sclk.
*/
module spm_host (
  // clock
  input  wire logic clk_i,
  // spi
  output logic      spi_sclk_o,
  output logic      spi_cs_n_o,
  output logic      spi_mosi_o,
  input  wire logic spi_miso_i
);
  timeunit 1ns;
  timeprecision 1ps;

  initial begin
    spi_sclk_o = 1'b0;
    spi_cs_n_o = 1'b1;
    spi_mosi_o = 1'b1;
  end

  task automatic xfer(input logic [1:0] cmd, input logic [4:0] addr, input logic [7:0] data,
                      input logic par_on, input logic bad, input int nbits,
                      output logic [15:0] rx);
    logic [15:0] f;
    f = {cmd, addr, 1'b0, data};
    if (cmd == 2'h0) f[8] = 1'b1;
    if (cmd == 2'h1 && par_on) f[8] = ~^f ^ bad;
    @(negedge clk_i) spi_cs_n_o = 1'b0;
    // fewer than 16 bits makes a cut frame
    for (int i = 15; i >= 16 - nbits; i--) begin
      repeat (3) @(negedge clk_i);
      spi_mosi_o = f[i];
      repeat (2) @(negedge clk_i);
      rx[i] = spi_miso_i;
      spi_sclk_o = 1'b1;
      repeat (2) @(negedge clk_i);
      spi_sclk_o = 1'b0;
    end
    repeat (2) @(negedge clk_i);
    // released line must not keep the last bit
    spi_mosi_o = ~spi_mosi_o;
    spi_cs_n_o = 1'b1;
    repeat (3) @(negedge clk_i);
  endtask
endmodule

/* verif/spm_regs_tb.sv */
/*
  self-checking bench for spm_regs against a register model.
  assumes the spm_host model drives the spi side.
*/
module spm_regs_tb
  import spm_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  logic       clk_i;
  logic       sys_rst_i;
  logic       sclk;
  logic       cs_n;
  logic       mosi;
  logic       miso;
  logic       par_en;
  logic       reg_on;
  logic       norm;
  logic [7:0] fix;
  logic [7:0] ext;
  logic [2:0] sel;
  logic       res;
  logic       att;
  logic       perr;
  logic [7:0] m [0:4];
  logic [2:0] r;
  logic [7:0] d;
  logic [15:0] rx_cut;
  int         failures;
  int         n_tests;
  int         seed;
  int         perr_n;
  int         perr_exp;

  spm_host host (.clk_i(clk_i), .spi_sclk_o(sclk), .spi_cs_n_o(cs_n), .spi_mosi_o(mosi),
                 .spi_miso_i(miso));

  spm_regs dut (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .spi_sclk_i(sclk), .spi_cs_n_i(cs_n),
                .spi_mosi_i(mosi), .spi_miso_o(miso), .parity_enable_i(par_en),
                .can_reg_on_i(reg_on), .normal_mode_i(norm), .fixed_status_i(fix),
                .extended_status_i(ext), .monitor_select_o(sel),
                .internal_sense_resistor_enable_o(res), .io_attenuation_o(att),
                .parity_error_o(perr));

  initial begin
    clk_i = 1'b0;
    forever #20 clk_i = ~clk_i;
  end

  always @(posedge clk_i) if (perr === 1'b1) perr_n++;

  task give_verdict;
    if (failures == 0 && n_tests > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string msg);
    n_tests++;
    if (got !== exp) begin
      failures++;
      $display("CHECK FAILED %0t %s", $time, msg);
    end
  endtask

  task automatic wr(input logic [4:0] a, input logic [7:0] v, input logic bad);
    logic [15:0] rx;
    host.xfer(2'h1, a, v, par_en, bad, 16, rx);
    chk(rx, {fix, ext}, "write status");
    if (par_en && bad) perr_exp++;
    else if (a == ADDR_MONITOR) begin
      if (reg_on && norm) m[0] = v & MON_WRITE_MASK;
    end else if (a <= ADDR_SCRATCH_D) m[a] = v;
  endtask

  task automatic rd(input logic [4:0] a);
    logic [15:0] rx;
    logic [7:0]  e;
    host.xfer(2'h0, a, 8'h00, par_en, 1'b0, 16, rx);
    e = (a <= ADDR_SCRATCH_D) ? m[a] : 8'h00;
    chk(rx, {fix, e}, "read back");
    chk({11'h0, sel, res, att}, {11'h0, m[0][7:4],
        m[0][3] & (m[0][7:5] == SRC_IO_FIRST || m[0][7:5] == SRC_IO_SECOND)},
        "monitor outputs");
    chk(16'(perr_n), 16'(perr_exp), "parity error count");
  endtask

  initial begin
    #2000000;
    failures++;
    give_verdict;
  end

  initial begin
    seed = 68878;
    sys_rst_i = 1'b1;
    par_en = 1'b0;
    reg_on = 1'b1;
    norm = 1'b1;
    fix = 8'ha5;
    ext = 8'h3c;
    m = '{default: 8'h00};
    repeat (2) @(negedge clk_i);
    sys_rst_i = 1'b0;
    repeat (2) @(negedge clk_i);
    for (int a = 0; a < 6; a++) rd(5'(a));
    for (int s = 0; s < 8; s++) begin
      wr(ADDR_MONITOR, {3'(s), 2'(s), 3'h7}, 1'b0);
      rd(ADDR_MONITOR);
    end
    for (int k = 0; k < 60; k++) begin
      if (k == 30) par_en = 1'b1;
      fix = 8'($random(seed));
      ext = 8'($random(seed));
      r = 3'($random(seed));
      d = 8'($random(seed));
      wr({2'h0, r}, d, par_en & d[0]);
      rd({2'h0, r});
    end
    host.xfer(2'h1, ADDR_SCRATCH_A, ~m[1], par_en, 1'b0, 12, rx_cut);
    rd(ADDR_SCRATCH_A);
    host.xfer(2'h3, ADDR_SCRATCH_D, ~m[4], par_en, 1'b1, 16, rx_cut);
    chk(rx_cut, {fix, ext}, "flag frame status");
    rd(ADDR_SCRATCH_D);
    wr(ADDR_MONITOR, 8'hff, 1'b0);
    reg_on = 1'b0;
    m[0] = MON_RESET;
    rd(ADDR_MONITOR);
    wr(ADDR_MONITOR, 8'h80, 1'b0);
    reg_on = 1'b1;
    for (int a = 0; a < 5; a++) rd(5'(a));
    wr(ADDR_MONITOR, 8'h98, 1'b0);
    norm = 1'b0;
    m[0] = MON_RESET;
    rd(ADDR_MONITOR);
    norm = 1'b1;
    @(negedge clk_i) sys_rst_i = 1'b1;
    m = '{default: 8'h00};
    repeat (2) @(negedge clk_i);
    sys_rst_i = 1'b0;
    repeat (2) @(negedge clk_i);
    for (int a = 0; a < 5; a++) rd(5'(a));
    give_verdict;
  end
endmodule
